/* File: rtl/core_reg_pkg.sv */
// Shared constants for the core register unit.
// Assumes one clock and an active-high asynchronous reset.
package core_reg_pkg;
  localparam int NUM_CORE_SPECIAL_REGS = 40;
  localparam logic [5:0] CR_PSW = 6'h00;
  localparam logic [5:0] CR_PREVIOUS_CONTEXT_LINK = 6'h01;
  localparam logic [5:0] CR_PC = 6'h02;
  localparam logic [5:0] CR_LAST = 6'h27;
  localparam logic [5:0] CR_CORE_REG_ACCESS_SPEC = 6'h25;
  localparam logic [31:0] PSW_RESET = 32'h0000_0880;
  localparam logic [31:0] PC_RESET = 32'hBFFF_FFFC;
  localparam logic [31:0] PSW_OVF_MASK = 32'h7800_0000;
  localparam logic [31:0] PC_BIT0_MASK = 32'hFFFF_FFFE;
  localparam logic [23:0] CORE_SPECIAL_REGS_WIN_TAG = 24'hFFFF_FF;
  localparam logic [3:0] REG_SP = 4'hA;
  localparam logic [3:0] REG_RA = 4'hB;
  localparam logic [3:0] REG_IMPLICIT = 4'hF;
  localparam int CAUSE_W = 5;
  localparam int CAUSE_PWR = 0;
  localparam int CAUSE_WARM = 1;
  localparam int CAUSE_SOFT = 2;
  localparam int CAUSE_WDT = 3;
  localparam int CAUSE_WAKE = 4;
  localparam logic [4:0] CAUSE_RESET = 5'h01;
  localparam logic [31:0] SOFT_KEY_ARM = 32'h0000_00A5;
  localparam logic [31:0] SOFT_KEY_GO = 32'h0000_005A;

  typedef enum logic [1:0] {
    OP_MOVE_FROM_CORE_REG_INSTR = 2'b00,
    OP_MOVE_TO_CORE_REG_INSTR = 2'b01,
    OP_OVERFLOW_CLEAR_INSTR = 2'b10,
    OP_NONE = 2'b11
  } op_e;

  typedef enum logic [1:0] {
    K_CORE_SPECIAL_REGS = 2'b00,
    K_AREG = 2'b01,
    K_DREG = 2'b10
  } ctx_kind_e;

  typedef enum logic {
    KEY_IDLE = 1'b0,
    KEY_ARMED = 1'b1
  } key_state_e;
endpackage : core_reg_pkg

/* File: rtl/core_reg_unit.sv */
// Core register unit: general registers, special registers,
// context transfer, mapped debug window and reset causes.
// Assumes pipeline and bus inputs are synchronous to REF_CLK.
`timescale 1ns/1ps
module core_reg_unit (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic POWER_ON_PIN,
  input wire logic WARM_RESET_PIN,
  input wire logic WATCHDOG_ERROR,
  input wire logic WAKEUP_PIN,
  input wire logic SOFT_RST_WR,
  input wire logic [31:0] SOFT_RST_DATA,
  output logic [4:0] RESET_CAUSE,
  output logic SYS_RESET,
  input wire logic INSTR_VALID,
  input wire logic [1:0] INSTR_OP,
  input wire logic INSTR_SHORT,
  input wire logic [5:0] CR_IDX,
  input wire logic [3:0] D_IDX,
  input wire logic SUPERVISOR,
  output logic PRIV_TRAP,
  input wire logic [3:0] D_RD_IDX,
  input wire logic [3:0] A_RD_IDX,
  input wire logic [2:0] E_RD_IDX,
  output logic [31:0] D_RDATA,
  output logic [31:0] A_RDATA,
  output logic [63:0] E_RDATA,
  input wire logic D_WR,
  input wire logic [3:0] D_WR_IDX,
  input wire logic [31:0] D_WDATA,
  input wire logic A_WR,
  input wire logic [3:0] A_WR_IDX,
  input wire logic [31:0] A_WDATA,
  input wire logic E_WR,
  input wire logic [2:0] E_WR_IDX,
  input wire logic [63:0] E_WDATA,
  input wire logic LINK_WR,
  input wire logic [31:0] LINK_ADDR,
  input wire logic PC_LOAD,
  input wire logic [31:0] PC_VALUE,
  output logic [31:0] PC_OUT,
  output logic [31:0] PSW_OUT,
  output logic [31:0] SP_OUT,
  input wire logic CTX_VALID,
  input wire logic CTX_RESTORE,
  input wire logic CTX_UPPER,
  input wire logic [3:0] CTX_WORD,
  input wire logic [31:0] CTX_WDATA,
  output logic [31:0] CTX_RDATA,
  output logic CTX_ACK,
  input wire logic BUS_REQ,
  input wire logic BUS_WE,
  input wire logic BUS_FROM_CORE,
  input wire logic [31:0] BUS_ADDR,
  input wire logic [31:0] BUS_WDATA,
  output logic [31:0] BUS_RDATA,
  output logic BUS_ACK,
  output logic MEM_TRAP,
  output logic CORE_REG_EVENT
);
  logic [31:0] core_special_regs_reg [0:core_reg_pkg::NUM_CORE_SPECIAL_REGS-1];
  logic [15:0][31:0] d_regs;
  logic [15:0][31:0] a_regs;
  logic sys_rst;
  logic move_to_core_reg_instr_ok;
  logic move_from_core_reg_instr_ok;
  logic overflow_clear_instr_go;
  logic bus_hit;
  logic bus_ok;
  logic [5:0] bus_idx;
  logic [5:0] ctx_m;
  logic ctx_rest;
  logic d_we;
  logic [3:0] d_widx;
  logic [31:0] d_wdat;
  logic a_we;
  logic [3:0] a_widx;
  logic [31:0] a_wdat;

  ////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] core_special_regs_rst(input int i);
    if (i == int'(core_reg_pkg::CR_PSW)) begin
      core_special_regs_rst = core_reg_pkg::PSW_RESET;
    end else if (i == int'(core_reg_pkg::CR_PC)) begin
      core_special_regs_rst = core_reg_pkg::PC_RESET;
    end else begin
      core_special_regs_rst = 32'h0000_0000;
    end
  endfunction : core_special_regs_rst

  function automatic logic [31:0] rd_core_special_regs(input logic [5:0] i);
    rd_core_special_regs = 32'h0000_0000;
    if (i <= core_reg_pkg::CR_LAST) begin
      rd_core_special_regs = core_special_regs_reg[i];
    end
    if (i == core_reg_pkg::CR_PC) begin
      rd_core_special_regs = rd_core_special_regs & core_reg_pkg::PC_BIT0_MASK;
    end
  endfunction : rd_core_special_regs

  // Context word to {kind, register}; globals never appear
  function automatic logic [5:0] ctx_map(input logic upper, input logic [3:0] w);
    logic [3:0] r;
    logic [1:0] k;
    r = 4'h0;
    k = core_reg_pkg::K_CORE_SPECIAL_REGS;
    if (upper) begin
      if (w < 4'h2) begin
        r = w[0] ? core_reg_pkg::CR_PSW[3:0] : core_reg_pkg::CR_PREVIOUS_CONTEXT_LINK[3:0];
      end else if (w < 4'h4) begin
        k = core_reg_pkg::K_AREG;
        r = 4'hA + (w - 4'h2);
      end else if (w < 4'h8) begin
        k = core_reg_pkg::K_DREG;
        r = 4'h8 + (w - 4'h4);
      end else if (w < 4'hC) begin
        k = core_reg_pkg::K_AREG;
        r = 4'hC + (w - 4'h8);
      end else begin
        k = core_reg_pkg::K_DREG;
        r = 4'hC + (w - 4'hC);
      end
    end else begin
      if (w == 4'h0) begin
        r = core_reg_pkg::CR_PREVIOUS_CONTEXT_LINK[3:0];
      end else if (w == 4'h1) begin
        k = core_reg_pkg::K_AREG;
        r = core_reg_pkg::REG_RA;
      end else if (w < 4'h4) begin
        k = core_reg_pkg::K_AREG;
        r = w;
      end else if (w < 4'h8) begin
        k = core_reg_pkg::K_DREG;
        r = w - 4'h4;
      end else if (w < 4'hC) begin
        k = core_reg_pkg::K_AREG;
        r = w - 4'h4;
      end else begin
        k = core_reg_pkg::K_DREG;
        r = w - 4'h8;
      end
    end
    ctx_map = {k, r};
  endfunction : ctx_map

  ////////////////////////////////////////////////////////////
  // Submodules
  reset_cause u_reset_cause (
    .clk(REF_CLK),
    .rst(RST),
    .pwr_pin(POWER_ON_PIN),
    .warm_pin(WARM_RESET_PIN),
    .wdt_err(WATCHDOG_ERROR),
    .wake_pin(WAKEUP_PIN),
    .soft_wr(SOFT_RST_WR),
    .soft_data(SOFT_RST_DATA),
    .cause(RESET_CAUSE),
    .sys_reset(sys_rst)
  );

  gpr_file u_gpr_file (
    .clk(REF_CLK),
    .rst(RST),
    .d_we(d_we),
    .d_widx(d_widx),
    .d_wdata(d_wdat),
    .a_we(a_we),
    .a_widx(a_widx),
    .a_wdata(a_wdat),
    .e_we(E_WR),
    .e_widx(E_WR_IDX),
    .e_wdata(E_WDATA),
    .d_regs(d_regs),
    .a_regs(a_regs)
  );

  assign SYS_RESET = sys_rst;

  ////////////////////////////////////////////////////////////
  // Request decode
  assign move_from_core_reg_instr_ok = INSTR_VALID && INSTR_OP == core_reg_pkg::OP_MOVE_FROM_CORE_REG_INSTR;
  assign move_to_core_reg_instr_ok = INSTR_VALID && INSTR_OP == core_reg_pkg::OP_MOVE_TO_CORE_REG_INSTR
    && SUPERVISOR && CR_IDX <= core_reg_pkg::CR_LAST;
  assign overflow_clear_instr_go = INSTR_VALID && INSTR_OP == core_reg_pkg::OP_OVERFLOW_CLEAR_INSTR;
  assign bus_hit = BUS_REQ && BUS_ADDR[31:8] == core_reg_pkg::CORE_SPECIAL_REGS_WIN_TAG;
  assign bus_ok = bus_hit && !BUS_FROM_CORE;
  assign bus_idx = BUS_ADDR[7:2];
  assign ctx_m = ctx_map(CTX_UPPER, CTX_WORD);
  assign ctx_rest = CTX_VALID && CTX_RESTORE;

  ////////////////////////////////////////////////////////////
  // Special registers; later writes take priority
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < core_reg_pkg::NUM_CORE_SPECIAL_REGS; i++) begin
        core_special_regs_reg[i] <= core_special_regs_rst(i);
      end
    end else if (sys_rst) begin
      for (int i = 0; i < core_reg_pkg::NUM_CORE_SPECIAL_REGS; i++) begin
        core_special_regs_reg[i] <= core_special_regs_rst(i);
      end
    end else begin
      if (PC_LOAD) begin
        core_special_regs_reg[core_reg_pkg::CR_PC] <= PC_VALUE;
      end
      if (overflow_clear_instr_go) begin
        core_special_regs_reg[core_reg_pkg::CR_PSW] <=
          core_special_regs_reg[core_reg_pkg::CR_PSW] & ~core_reg_pkg::PSW_OVF_MASK;
      end
      if (move_to_core_reg_instr_ok) begin
        core_special_regs_reg[CR_IDX] <= d_regs[D_IDX];
      end
      if (bus_ok && BUS_WE && bus_idx <= core_reg_pkg::CR_LAST) begin
        core_special_regs_reg[bus_idx] <= BUS_WDATA;
      end
      if (ctx_rest && ctx_m[5:4] == core_reg_pkg::K_CORE_SPECIAL_REGS) begin
        core_special_regs_reg[{2'b00, ctx_m[3:0]}] <= CTX_WDATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // General register write select
  always_comb begin
    d_we = 1'b1;
    d_widx = D_WR_IDX;
    d_wdat = D_WDATA;
    if (ctx_rest && ctx_m[5:4] == core_reg_pkg::K_DREG) begin
      d_widx = ctx_m[3:0];
      d_wdat = CTX_WDATA;
    end else if (move_from_core_reg_instr_ok) begin
      d_widx = D_IDX;
      d_wdat = rd_core_special_regs(CR_IDX);
    end else begin
      d_we = D_WR;
    end
  end

  always_comb begin
    a_we = 1'b1;
    a_widx = A_WR_IDX;
    a_wdat = A_WDATA;
    if (ctx_rest && ctx_m[5:4] == core_reg_pkg::K_AREG) begin
      a_widx = ctx_m[3:0];
      a_wdat = CTX_WDATA;
    end else if (LINK_WR) begin
      a_widx = core_reg_pkg::REG_RA;
      a_wdat = LINK_ADDR;
    end else begin
      a_we = A_WR;
    end
  end

  ////////////////////////////////////////////////////////////
  // Operand reads
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      D_RDATA <= 32'h0000_0000;
      A_RDATA <= 32'h0000_0000;
      E_RDATA <= 64'h0000_0000_0000_0000;
    end else begin
      D_RDATA <= d_regs[INSTR_SHORT ? core_reg_pkg::REG_IMPLICIT : D_RD_IDX];
      A_RDATA <= a_regs[INSTR_SHORT ? core_reg_pkg::REG_IMPLICIT : A_RD_IDX];
      E_RDATA <= {d_regs[{E_RD_IDX, 1'b1}], d_regs[{E_RD_IDX, 1'b0}]};
    end
  end

  assign PC_OUT = rd_core_special_regs(core_reg_pkg::CR_PC);
  assign PSW_OUT = core_special_regs_reg[core_reg_pkg::CR_PSW];
  assign SP_OUT = a_regs[core_reg_pkg::REG_SP];

  ////////////////////////////////////////////////////////////
  // Context save data
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      CTX_RDATA <= 32'h0000_0000;
      CTX_ACK <= 1'b0;
    end else begin
      CTX_ACK <= CTX_VALID;
      if (CTX_VALID && !CTX_RESTORE) begin
        case (ctx_m[5:4])
          core_reg_pkg::K_AREG: CTX_RDATA <= a_regs[ctx_m[3:0]];
          core_reg_pkg::K_DREG: CTX_RDATA <= d_regs[ctx_m[3:0]];
          default: CTX_RDATA <= rd_core_special_regs({2'b00, ctx_m[3:0]});
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Mapped window and traps
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      BUS_RDATA <= 32'h0000_0000;
      BUS_ACK <= 1'b0;
      MEM_TRAP <= 1'b0;
    end else begin
      BUS_ACK <= bus_ok;
      MEM_TRAP <= bus_hit && BUS_FROM_CORE;
      if (bus_ok && !BUS_WE) begin
        BUS_RDATA <= rd_core_special_regs(bus_idx);
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      PRIV_TRAP <= 1'b0;
      CORE_REG_EVENT <= 1'b0;
    end else begin
      PRIV_TRAP <= INSTR_VALID && INSTR_OP == core_reg_pkg::OP_MOVE_TO_CORE_REG_INSTR && !SUPERVISOR;
      CORE_REG_EVENT <= move_to_core_reg_instr_ok && core_special_regs_reg[core_reg_pkg::CR_CORE_REG_ACCESS_SPEC][0];
    end
  end
endmodule : core_reg_unit

/* File: rtl/gpr_file.sv */
// Sixteen data and sixteen address registers.
// Assumes at most one writer per port per cycle.
`timescale 1ns/1ps
module gpr_file (
  input wire logic clk,
  input wire logic rst,
  input wire logic d_we,
  input wire logic [3:0] d_widx,
  input wire logic [31:0] d_wdata,
  input wire logic a_we,
  input wire logic [3:0] a_widx,
  input wire logic [31:0] a_wdata,
  input wire logic e_we,
  input wire logic [2:0] e_widx,
  input wire logic [63:0] e_wdata,
  output logic [15:0][31:0] d_regs,
  output logic [15:0][31:0] a_regs
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      d_regs <= '0;
    end else begin
      if (e_we) begin
        d_regs[{e_widx, 1'b0}] <= e_wdata[31:0];
        d_regs[{e_widx, 1'b1}] <= e_wdata[63:32];
      end
      if (d_we) begin
        d_regs[d_widx] <= d_wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_regs <= '0;
    end else if (a_we) begin
      a_regs[a_widx] <= a_wdata;
    end
  end
endmodule : gpr_file

/* File: rtl/reset_cause.sv */
// Reset source collector with guarded software request.
// Assumes synchronous inputs; RST is the cold reset.
`timescale 1ns/1ps
module reset_cause (
  input wire logic clk,
  input wire logic rst,
  input wire logic pwr_pin,
  input wire logic warm_pin,
  input wire logic wdt_err,
  input wire logic wake_pin,
  input wire logic soft_wr,
  input wire logic [31:0] soft_data,
  output logic [4:0] cause,
  output logic sys_reset
);
  logic [4:0] lvl_reg;
  logic [4:0] rise;
  logic soft_go;
  core_reg_pkg::key_state_e key_reg;

  assign soft_go = soft_wr && key_reg == core_reg_pkg::KEY_ARMED
    && soft_data == core_reg_pkg::SOFT_KEY_GO;
  assign rise = {wake_pin, wdt_err, 1'b0, warm_pin, pwr_pin} & ~lvl_reg;

  ////////////////////////////////////////////////////////////
  // Two-step key
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_reg <= core_reg_pkg::KEY_IDLE;
    end else if (soft_wr) begin
      case (key_reg)
        core_reg_pkg::KEY_IDLE: begin
          if (soft_data == core_reg_pkg::SOFT_KEY_ARM) begin
            key_reg <= core_reg_pkg::KEY_ARMED;
          end
        end
        default: key_reg <= core_reg_pkg::KEY_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // Cause capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lvl_reg <= 5'h00;
      cause <= core_reg_pkg::CAUSE_RESET;
      sys_reset <= 1'b0;
    end else begin
      lvl_reg <= {wake_pin, wdt_err, 1'b0, warm_pin, pwr_pin};
      sys_reset <= |rise || soft_go;
      if (|rise || soft_go) begin
        cause <= rise | {2'b00, soft_go, 2'b00};
      end
    end
  end
endmodule : reset_cause

/* File: verif/core_reg_unit_sva.sv */
// Concurrent checks on the core register unit ports.
// Assumes one clock domain and bind to every instance.
`timescale 1ns/1ps
module core_reg_unit_sva (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic WARM_RESET_PIN,
  input wire logic [4:0] RESET_CAUSE,
  input wire logic SYS_RESET,
  input wire logic INSTR_VALID,
  input wire logic [1:0] INSTR_OP,
  input wire logic SUPERVISOR,
  input wire logic PRIV_TRAP,
  input wire logic A_WR,
  input wire logic LINK_WR,
  input wire logic [3:0] A_WR_IDX,
  input wire logic [31:0] A_WDATA,
  input wire logic [31:0] PSW_OUT,
  input wire logic [31:0] SP_OUT,
  input wire logic CTX_VALID,
  input wire logic CTX_RESTORE,
  input wire logic CTX_ACK,
  input wire logic BUS_REQ,
  input wire logic BUS_WE,
  input wire logic BUS_FROM_CORE,
  input wire logic [31:0] BUS_ADDR,
  input wire logic BUS_ACK,
  input wire logic MEM_TRAP,
  input wire logic CORE_REG_EVENT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic win;
  assign win = BUS_REQ && BUS_ADDR[31:8] == core_reg_pkg::CORE_SPECIAL_REGS_WIN_TAG;
  ////////////////////////////////////////////////////////////////
  priv_trap_a: assert property (INSTR_VALID && INSTR_OP == 2'h1 && !SUPERVISOR |=> PRIV_TRAP)
    else $error("missing privilege trap");
  no_trap_a: assert property (INSTR_VALID && (INSTR_OP != 2'h1 || SUPERVISOR) |=> !PRIV_TRAP)
    else $error("unexpected privilege trap");
  bus_ack_a: assert property (win && !BUS_FROM_CORE |=> BUS_ACK && !MEM_TRAP)
    else $error("window access not acknowledged");
  bus_trap_a: assert property (win && BUS_FROM_CORE |=> MEM_TRAP && !BUS_ACK)
    else $error("core window access not trapped");
  ack_cause_a: assert property (BUS_ACK |-> $past(BUS_REQ) && !$past(BUS_FROM_CORE))
    else $error("acknowledge without request");
  ovf_clear_a: assert property (INSTR_VALID && INSTR_OP == 2'h2 && !SYS_RESET && !(BUS_REQ && BUS_WE)
    && !(CTX_VALID && CTX_RESTORE) |=> (PSW_OUT & core_reg_pkg::PSW_OVF_MASK) == 32'h0
    && (PSW_OUT & ~core_reg_pkg::PSW_OVF_MASK) == ($past(PSW_OUT) & ~core_reg_pkg::PSW_OVF_MASK))
    else $error("overflow clear wrong");
  sp_write_a: assert property (A_WR && !LINK_WR && A_WR_IDX == core_reg_pkg::REG_SP && !(CTX_VALID && CTX_RESTORE)
    |=> SP_OUT == $past(A_WDATA))
    else $error("stack pointer view wrong");
  ctx_ack_a: assert property (CTX_VALID |=> CTX_ACK)
    else $error("context word not acknowledged");
  warm_cause_a: assert property ($rose(WARM_RESET_PIN) |=> SYS_RESET ##[0:1] RESET_CAUSE == 5'h02)
    else $error("warm reset cause wrong");
  core_event_a: assert property (CORE_REG_EVENT |-> $past(INSTR_VALID && INSTR_OP == 2'h1 && SUPERVISOR))
    else $error("access event without move-to");
endmodule : core_reg_unit_sva
bind core_reg_unit core_reg_unit_sva chk (
  .REF_CLK(REF_CLK), .RST(RST), .WARM_RESET_PIN(WARM_RESET_PIN), .RESET_CAUSE(RESET_CAUSE),
  .SYS_RESET(SYS_RESET), .INSTR_VALID(INSTR_VALID), .INSTR_OP(INSTR_OP), .SUPERVISOR(SUPERVISOR),
  .PRIV_TRAP(PRIV_TRAP), .A_WR(A_WR), .LINK_WR(LINK_WR), .A_WR_IDX(A_WR_IDX), .A_WDATA(A_WDATA), .PSW_OUT(PSW_OUT),
  .SP_OUT(SP_OUT), .CTX_VALID(CTX_VALID), .CTX_RESTORE(CTX_RESTORE), .CTX_ACK(CTX_ACK),
  .BUS_REQ(BUS_REQ), .BUS_WE(BUS_WE), .BUS_FROM_CORE(BUS_FROM_CORE), .BUS_ADDR(BUS_ADDR),
  .BUS_ACK(BUS_ACK), .MEM_TRAP(MEM_TRAP), .CORE_REG_EVENT(CORE_REG_EVENT)
);

/* File: verif/debug_host.sv */
// Debug host model issuing single window requests.
// Assumes go is driven non-blocking at the falling edge.
`timescale 1ns/1ps
module debug_host (
  input wire logic clk,
  input wire logic go,
  input wire logic we,
  input wire logic core,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  output logic req,
  output logic bus_we,
  output logic from_core,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_wdata
);
  initial begin
    req = 1'h0;
    bus_we = 1'h0;
    from_core = 1'h0;
    bus_addr = 32'h0;
    bus_wdata = 32'h0;
  end
  // One-cycle request per go pulse; idle address and data lines toggle
  always @(negedge clk) begin
    req <= go;
    bus_we <= go & we;
    from_core <= go & core;
    bus_addr <= go ? addr : ~bus_addr;
    bus_wdata <= go ? wdata : ~bus_wdata;
  end
endmodule : debug_host

/* File: verif/tb_top.sv */
// Self-checking bench for the core register unit.
// Assumes the debug host model and the bound checker.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [3:0] pins = 4'h0;
  logic [7:0] st = 8'h0;
  logic [1:0] op = 2'h3;
  logic sup = 1'h0, sh = 1'h0, crest = 1'h0, cup = 1'h0;
  logic go = 1'h0, bwe = 1'h0, bcore = 1'h0;
  logic [5:0] cr = 6'h0;
  logic [3:0] wi = 4'h0;
  logic [10:0] ri = 11'h0;
  logic [31:0] baddr = 32'h0, bd = 32'h0, r = 32'h0, r2 = 32'h0;
  logic [63:0] ed = 64'h0;
  logic req, we, fc, bus_ack, ctx_ack;
  logic [31:0] ba, bw, bus_rd, ctx_rd;
  logic [4:0] cause;
  logic [31:0] bq[$], cq[$];
  logic bk[$], kq[$];
  logic [31:0] d_rd;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;

  initial forever #25 clk = ~clk;

  debug_host host (.clk(clk), .go(go), .we(bwe), .core(bcore), .addr(baddr), .wdata(bd),
    .req(req), .bus_we(we), .from_core(fc), .bus_addr(ba), .bus_wdata(bw));

  core_reg_unit dut (.REF_CLK(clk), .RST(rst), .POWER_ON_PIN(pins[0]), .WARM_RESET_PIN(pins[1]),
    .WATCHDOG_ERROR(pins[2]), .WAKEUP_PIN(pins[3]), .SOFT_RST_WR(st[7]), .SOFT_RST_DATA(ed[31:0]),
    .RESET_CAUSE(cause), .SYS_RESET(), .INSTR_VALID(st[6]), .INSTR_OP(op), .INSTR_SHORT(sh),
    .CR_IDX(cr), .D_IDX(wi), .SUPERVISOR(sup), .PRIV_TRAP(), .D_RD_IDX(ri[3:0]), .A_RD_IDX(ri[7:4]),
    .E_RD_IDX(ri[10:8]), .D_RDATA(d_rd), .A_RDATA(), .E_RDATA(), .D_WR(st[0]), .D_WR_IDX(wi),
    .D_WDATA(ed[31:0]), .A_WR(st[1]), .A_WR_IDX(wi), .A_WDATA(ed[31:0]), .E_WR(st[2]),
    .E_WR_IDX(wi[2:0]), .E_WDATA(ed), .LINK_WR(st[3]), .LINK_ADDR(ed[31:0]), .PC_LOAD(st[4]),
    .PC_VALUE(ed[31:0]), .PC_OUT(), .PSW_OUT(), .SP_OUT(), .CTX_VALID(st[5]), .CTX_RESTORE(crest),
    .CTX_UPPER(cup), .CTX_WORD(wi), .CTX_WDATA(ed[31:0]), .CTX_RDATA(ctx_rd), .CTX_ACK(ctx_ack),
    .BUS_REQ(req), .BUS_WE(we), .BUS_FROM_CORE(fc), .BUS_ADDR(ba), .BUS_WDATA(bw),
    .BUS_RDATA(bus_rd), .BUS_ACK(bus_ack), .MEM_TRAP(), .CORE_REG_EVENT());
  ////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  task automatic give_verdict;
    n_mismatch += bq.size() + cq.size() + bk.size() + kq.size();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic pulse(input logic [7:0] s);
    @(negedge clk);
    st = s;
    @(negedge clk);
    st = 8'h0;
  endtask : pulse
  task automatic wr(input logic [7:0] s, input logic [3:0] i, input logic [63:0] v);
    wi = i;
    ed = v;
    pulse(s);
  endtask : wr
  task automatic ins(input logic [1:0] o, input logic s, input logic h, input logic [5:0] c,
    input logic [3:0] d);
    op = o;
    sup = s;
    sh = h;
    cr = c;
    wi = d;
    pulse(8'h40);
  endtask : ins
  task automatic ctx(input logic rs, input logic u, input logic [3:0] w, input logic [31:0] v);
    crest = rs;
    cup = u;
    if (!rs) cq.push_back(v);
    kq.push_back(rs);
    wr(8'h20, w, {32'h0, v});
  endtask : ctx
  task automatic bus(input logic w, input logic c, input logic [7:0] a, input logic [31:0] d);
    if (!c) bk.push_back(w);
    @(negedge clk);
    go <= 1'h1;
    bwe <= w;
    bcore <= c;
    baddr <= {24'hFFFFFF, a};
    bd <= d;
    @(negedge clk);
    go <= 1'h0;
    repeat (3) @(negedge clk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bq.push_back(e);
    bus(1'h0, 1'h0, a, 32'h0);
  endtask : rd
  ////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    ri <= 11'($urandom);
    if (bus_ack === 1'h1 && (bk.size() == 0 || !bk.pop_front()))
      cmp(bq.size() > 0 ? bq.pop_front() : ~bus_rd, bus_rd);
    if (ctx_ack === 1'h1 && (kq.size() == 0 || !kq.pop_front()))
      cmp(cq.size() > 0 ? cq.pop_front() : ~ctx_rd, ctx_rd);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(44));
    r = $urandom;
    r2 = $urandom;
    repeat (3) @(negedge clk);
    rst = 1'h0;
    rd(8'h00, core_reg_pkg::PSW_RESET);
    rd(8'h08, core_reg_pkg::PC_RESET);
    wr(8'h01, 4'h3, {32'h0, r});
    ins(2'h1, 1'h1, 1'h0, 6'h09, 4'h3);
    rd(8'h24, r);
    wr(8'h01, 4'h4, {32'h0, ~r});
    ins(2'h1, 1'h0, 1'h0, 6'h09, 4'h4);
    rd(8'h24, r);
    ins(2'h0, 1'h0, 1'h0, 6'h09, 4'h8);
    ctx(1'h0, 1'h1, 4'h4, r);
    wr(8'h01, 4'h5, {32'h0, 32'hF800_0880});
    ins(2'h1, 1'h1, 1'h0, core_reg_pkg::CR_PSW, 4'h5);
    ins(2'h2, 1'h0, 1'h0, 6'h00, 4'h0);
    rd(8'h00, 32'h8000_0880);
    wr(8'h01, 4'hF, {32'h0, r2});
    ins(2'h1, 1'h1, 1'h1, 6'h09, 4'hF);
    cmp(r2, d_rd);
    rd(8'h24, r2);
    bus(1'h1, 1'h0, 8'h24, r ^ r2);
    rd(8'h24, r ^ r2);
    bus(1'h0, 1'h1, 8'h24, 32'h0);
    bus(1'h1, 1'h1, 8'h24, r);
    rd(8'h24, r ^ r2);
    wr(8'h10, 4'h0, {32'h0, r | 32'h1});
    rd(8'h08, (r | 32'h1) & core_reg_pkg::PC_BIT0_MASK);
    wr(8'h02, core_reg_pkg::REG_SP, {32'h0, r});
    wr(8'h08, 4'h0, {32'h0, r2});
    ctx(1'h0, 1'h1, 4'h2, r);
    ctx(1'h0, 1'h1, 4'h3, r2);
    wr(8'h04, 4'h1, {r, r2});
    ctx(1'h0, 1'h0, 4'h6, r2);
    ctx(1'h0, 1'h0, 4'h7, r);
    ctx(1'h1, 1'h0, 4'h2, ~r);
    ctx(1'h0, 1'h0, 4'h2, ~r);
    ctx(1'h1, 1'h1, 4'h1, 32'h8000_0881);
    rd(8'h00, 32'h8000_0881);
    bus(1'h1, 1'h0, 8'h94, 32'h1);
    ins(2'h1, 1'h1, 1'h0, 6'h09, 4'h3);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      pins[i] = 1'h1;
      repeat (4) @(negedge clk);
      cmp({27'h0, cause}, {27'h0, 5'h01 << (i + int'(i > 1))});
      pins[i] = 1'h0;
    end
    wr(8'h80, 4'h0, {32'h0, core_reg_pkg::SOFT_KEY_ARM});
    wr(8'h80, 4'h0, 64'h11);
    wr(8'h80, 4'h0, {32'h0, core_reg_pkg::SOFT_KEY_GO});
    repeat (3) @(negedge clk);
    cmp({27'h0, cause}, 32'h10);
    wr(8'h80, 4'h0, {32'h0, core_reg_pkg::SOFT_KEY_ARM});
    wr(8'h80, 4'h0, {32'h0, core_reg_pkg::SOFT_KEY_GO});
    repeat (3) @(negedge clk);
    cmp({27'h0, cause}, 32'h04);
    rd(8'h00, core_reg_pkg::PSW_RESET);
    ctx(1'h0, 1'h1, 4'h4, r);
    repeat (4) @(negedge clk);
    give_verdict();
  end
endmodule : tb_top
